// File: common/fdc_regs_pkg.sv
// Offsets, field positions, reset values and tables of the floppy register set
package fdc_regs_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [2:0] OFF_PIN_STATUS_A  = 3'h0;
	localparam logic [2:0] OFF_PIN_STATUS_B  = 3'h1;
	localparam logic [2:0] OFF_OUTPUT_CTRL   = 3'h2;
	localparam logic [2:0] OFF_TAPE_ASSIGN   = 3'h3;
	localparam logic [2:0] OFF_MAIN_RATE     = 3'h4;
	localparam logic [2:0] OFF_CMD_DATA_FIFO = 3'h5;
	localparam logic [2:0] OFF_INPUT_CHECK   = 3'h7;

	// ****************************************************************
	// Output control fields
	// ****************************************************************
	localparam int         OC_SEL_LSB   = 0;
	localparam int         OC_RESET_N   = 2;
	localparam int         OC_DMA_EN    = 3;
	localparam int         OC_MOTOR_A   = 4;
	localparam int         OC_MOTOR_B   = 5;
	localparam logic [7:0] OC_RESET_VAL = 8'h00;

	// ****************************************************************
	// Rate, precompensation and rate-config fields
	// ****************************************************************
	localparam int         RP_SOFT_RESET = 7;
	localparam int         RP_POWER_DOWN = 6;
	localparam int         RP_SHIFT_LSB  = 2;
	localparam int         RC_NO_PRECOMP = 2;
	localparam logic [1:0] RATE_500K     = 2'h0;
	localparam logic [1:0] RATE_300K     = 2'h1;
	localparam logic [1:0] RATE_250K     = 2'h2;
	localparam logic [1:0] RATE_1M       = 2'h3;
	localparam logic [1:0] TAPE_RATE_2M  = 2'h2;
	localparam logic [1:0] RATE_RESET    = 2'h0;
	localparam logic [2:0] SHIFT_DEFAULT = 3'h0;
	localparam logic [2:0] SHIFT_OFF     = 3'h7;

	// Delays in units of 10 ps, indexed by shift_delay_code
	localparam logic [15:0] DELAY_NORMAL [0:7] = '{16'h0000, 16'd4167, 16'd8334, 16'd12500,
		16'd16667, 16'd20833, 16'd25000, 16'h0000};
	localparam logic [15:0] DELAY_TAPE [0:7] = '{16'h0000, 16'd2080, 16'd4117, 16'd6250,
		16'd8330, 16'd10420, 16'd12500, 16'h0000};
	localparam logic [15:0] DEFAULT_LOW_RATE = 16'd12500;
	localparam logic [15:0] DEFAULT_1M       = 16'd4167;
	localparam logic [15:0] DEFAULT_2M       = 16'd2080;

	// ****************************************************************
	// Status byte zero interrupt codes
	// ****************************************************************
	localparam logic [1:0] INT_CODE_INVALID  = 2'h2;
	localparam logic [1:0] INT_CODE_READY_CH = 2'h3;

	// ****************************************************************
	// Misc
	// ****************************************************************
	localparam logic [7:0] BYTE_ZERO    = 8'h00;
	localparam logic [7:0] BYTE_ONES    = 8'hFF;
	localparam int         SYNC_PINS    = 6;

	typedef enum logic [1:0] {
		MODE_AT,
		MODE_PRIMARY,
		MODE_SECONDARY
	} compat_mode_t;

endpackage

// File: common/edge_track_if.sv
// Carrier between the status bank and one edge tracker
`timescale 1ns/10ps
interface edge_track_if;
	logic level;
	logic clr;
	logic toggle;
	logic flag;

	modport tracker (
		input  level,
		input  clr,
		output toggle,
		output flag
	);
	modport user (
		output level,
		output clr,
		input  toggle,
		input  flag
	);
endinterface

// File: hw/edge_track.sv
// Rising edge toggle and sticky flag for one monitored signal
`timescale 1ns/10ps
module edge_track (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	edge_track_if.tracker     trk
);
	logic prev_r;
	logic prev_nxt;
	logic toggle_r;
	logic toggle_nxt;
	logic flag_r;
	logic flag_nxt;

	always_comb begin
		prev_nxt   = trk.level;
		toggle_nxt = toggle_r;
		flag_nxt   = flag_r;
		if (trk.clr) begin
			flag_nxt = 1'b0;
		end
		// Set beats clear so an edge is never lost
		if (trk.level && !prev_r) begin
			toggle_nxt = ~toggle_r;
			flag_nxt   = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prev_r   <= 1'b0;
			toggle_r <= 1'b0;
			flag_r   <= 1'b0;
		end else begin
			prev_r   <= prev_nxt;
			toggle_r <= toggle_nxt;
			flag_r   <= flag_nxt;
		end
	end

	assign trk.toggle = toggle_r;
	assign trk.flag   = flag_r;
endmodule

// File: hw/floppy_host_status_regs.sv
// Host register bank of the floppy controller
//
// Behaviour
// [RQ1] Pin status A reads at offset 0, pin status B at offset 1.
// [RQ2] Status A bit 7 returns the interrupt output level in both modes.
// [RQ3] Primary status A: bit5 step, bit4 track zero, bit3 side, bit2 index.
// [RQ4] Primary status A: bit1 low when protected, bit0 high for inward moves.
// [RQ5] Secondary status A: bit6 DMA request, bit5 inverse of latched step.
// [RQ6] Secondary status A bits 4..0 carry inverted polarities of primary.
// [RQ7] Primary status B: bit5 drive select bit 0, bits2..0 gate and motors.
// [RQ8] Primary status B bits 4 and 3 toggle on write and read data edges.
// [RQ9] Secondary status B: bits1,0 low when D/C selected; bits6,5 select pins.
// [RQ10] Secondary status B bits 4..2 are inverted latches of data and gate.
// [RQ11] Output control register clears fully while master reset is held.
// [RQ12] Tape select bits 1:0 pick no drive or drives 1 to 3.
// [RQ13] Three-mode tape register shows media ID and boot drive from config.
// [RQ14] Three-mode bits 5:4 show the drive-type pair of last selected drive.
// [RQ15] Effective rate follows whichever rate register was written last.
// [RQ16] Rate register bit 7 pulses software reset; bit 6 selects power-down.
// [RQ17] Shift code picks precompensation steps, halved at tape rate, 111 off.
// [RQ18] Default shift delay is 125, 41.67 or 20.8 ns by data rate.
// [RQ19] Rate code sets data rate and the low write current output.
// [RQ20] Tape 2M rate only for rate code 01 with tape rate code 10.
// [RQ21] Data FIFO starts disabled; only the configure command enables it.
// [RQ22] Status byte zero code is 10 for invalid, 11 for ready change.
// [RQ23] AT mode input check drives only bit 7, inverse of media change.
// [RQ24] Primary input check: bits 6..3 high, bits 2:1 current rate code.
// [RQ25] One mode input steers every mode-dependent status bit.
`timescale 1ns/10ps
module floppy_host_status_regs (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        bus_cs,
	input  wire logic        bus_rd,
	input  wire logic        bus_wr,
	input  wire logic [2:0]  bus_addr,
	input  wire logic [7:0]  bus_wdata,
	output logic      [7:0]  bus_rdata,
	output logic      [7:0]  bus_rdata_oe_n,
	input  wire logic [1:0]  compat_mode,
	input  wire logic        three_rate_enable,
	input  wire logic [3:0]  config_reg_eight,
	input  wire logic [7:0]  drive_type_config,
	input  wire logic [1:0]  tape_rate_code,
	input  wire logic        second_drive_flag,
	input  wire logic        irq_level,
	input  wire logic        dma_request_out,
	input  wire logic        step_out_n,
	input  wire logic        head_out_n,
	input  wire logic        dir_out,
	input  wire logic        write_gate_n,
	input  wire logic        write_serial_out,
	input  wire logic [7:0]  main_flow_status,
	input  wire logic [7:0]  fifo_rdata,
	input  wire logic        cfg_strobe,
	input  wire logic        cfg_fifo_enable,
	input  wire logic        cmd_invalid,
	input  wire logic        ready_changed,
	input  wire logic [1:0]  normal_int_code,
	input  wire logic        track_zero_in,
	input  wire logic        index_in,
	input  wire logic        write_protect_n,
	input  wire logic        read_data_in,
	input  wire logic        media_changed_in,
	output logic             motor_a_out_n,
	output logic             motor_b_out_n,
	output logic             select_a_out_n,
	output logic             select_b_out_n,
	output logic             drive_c_selected_n,
	output logic             drive_d_selected_n,
	output logic             ctrl_reset_n,
	output logic             dma_irq_enable,
	output logic             soft_reset_pulse,
	output logic             power_down,
	output logic      [1:0]  rate_code,
	output logic             low_write_current,
	output logic             tape_2m_rate,
	output logic      [15:0] precomp_delay,
	output logic             no_precomp,
	output logic      [1:0]  tape_select,
	output logic             fifo_enabled,
	output logic             fifo_wr_pulse,
	output logic             fifo_rd_pulse,
	output logic      [7:0]  fifo_wdata,
	output logic      [1:0]  st0_int_code
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	localparam int NP = fdc_regs_pkg::SYNC_PINS;
	logic [NP-1:0] pins_raw;
	logic [NP-1:0] sync1_r;
	logic [NP-1:0] sync2_r;
	logic          trk0_s;
	logic          index_s;
	logic          wp_n_s;
	logic          rdata_s;
	logic          media_changed_in_s;

	assign pins_raw = {1'b0, media_changed_in, read_data_in, write_protect_n, index_in,
		track_zero_in};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
		end
	end

	assign trk0_s   = sync2_r[0];
	assign index_s  = sync2_r[1];
	assign wp_n_s   = sync2_r[2];
	assign rdata_s  = sync2_r[3];
	assign media_changed_in_s = sync2_r[4];

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	fdc_regs_pkg::compat_mode_t mode;
	logic is_secondary;
	logic is_at;

	// [RQ25] single mode source
	assign mode         = fdc_regs_pkg::compat_mode_t'(compat_mode);
	assign is_secondary = (mode == fdc_regs_pkg::MODE_SECONDARY);
	assign is_at        = (mode == fdc_regs_pkg::MODE_AT);

	// ****************************************************************
	// Write side registers
	// ****************************************************************
	logic [7:0] out_ctrl_r;
	logic [7:0] out_ctrl_nxt;
	logic [1:0] tape_sel_r;
	logic [1:0] tape_sel_nxt;
	logic [1:0] rate_r;
	logic [1:0] rate_nxt;
	logic [2:0] shift_r;
	logic [2:0] shift_nxt;
	logic       pdown_r;
	logic       pdown_nxt;
	logic       noprec_r;
	logic       noprec_nxt;
	logic       sreset_r;
	logic       sreset_nxt;
	logic       fifo_en_r;
	logic       fifo_en_nxt;
	logic       fwr_r;
	logic       fwr_nxt;
	logic [7:0] fwdata_r;
	logic [7:0] fwdata_nxt;
	logic       wr_hit;

	assign wr_hit = bus_cs && bus_wr;

	always_comb begin
		out_ctrl_nxt = out_ctrl_r;
		tape_sel_nxt = tape_sel_r;
		rate_nxt     = rate_r;
		shift_nxt    = shift_r;
		pdown_nxt    = pdown_r;
		noprec_nxt   = noprec_r;
		sreset_nxt   = 1'b0;
		fwr_nxt      = 1'b0;
		fwdata_nxt   = fwdata_r;
		fifo_en_nxt  = fifo_en_r;
		// [RQ21] only configure changes FIFO mode
		if (cfg_strobe) begin
			fifo_en_nxt = cfg_fifo_enable;
		end
		if (wr_hit) begin
			unique case (bus_addr)
				fdc_regs_pkg::OFF_OUTPUT_CTRL: begin
					out_ctrl_nxt = bus_wdata;
				end
				// [RQ12] tape drive number
				fdc_regs_pkg::OFF_TAPE_ASSIGN: begin
					tape_sel_nxt = bus_wdata[1:0];
				end
				// [RQ15] last writer sets rate
				fdc_regs_pkg::OFF_MAIN_RATE: begin
					rate_nxt   = bus_wdata[1:0];
					shift_nxt  = bus_wdata[fdc_regs_pkg::RP_SHIFT_LSB +: 3];
					// [RQ16] power-down and reset
					pdown_nxt  = bus_wdata[fdc_regs_pkg::RP_POWER_DOWN];
					sreset_nxt = bus_wdata[fdc_regs_pkg::RP_SOFT_RESET];
				end
				fdc_regs_pkg::OFF_CMD_DATA_FIFO: begin
					fwr_nxt    = 1'b1;
					fwdata_nxt = bus_wdata;
				end
				// [RQ15] rate config write
				fdc_regs_pkg::OFF_INPUT_CHECK: begin
					rate_nxt   = bus_wdata[1:0];
					noprec_nxt = bus_wdata[fdc_regs_pkg::RC_NO_PRECOMP];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			// [RQ11] master reset clears all bits
			out_ctrl_r <= fdc_regs_pkg::OC_RESET_VAL;
			tape_sel_r <= 2'h0;
			rate_r     <= fdc_regs_pkg::RATE_RESET;
			shift_r    <= fdc_regs_pkg::SHIFT_DEFAULT;
			pdown_r    <= 1'b0;
			noprec_r   <= 1'b0;
			sreset_r   <= 1'b0;
			fwr_r      <= 1'b0;
			fwdata_r   <= fdc_regs_pkg::BYTE_ZERO;
			// [RQ21] FIFO disabled after reset
			fifo_en_r  <= 1'b0;
		end else begin
			out_ctrl_r <= out_ctrl_nxt;
			tape_sel_r <= tape_sel_nxt;
			rate_r     <= rate_nxt;
			shift_r    <= shift_nxt;
			pdown_r    <= pdown_nxt;
			noprec_r   <= noprec_nxt;
			sreset_r   <= sreset_nxt;
			fwr_r      <= fwr_nxt;
			fwdata_r   <= fwdata_nxt;
			fifo_en_r  <= fifo_en_nxt;
		end
	end

	// ****************************************************************
	// Drive side decodes
	// ****************************************************************
	logic [1:0] dsel;
	logic       motor_a_on;
	logic       motor_b_on;

	assign dsel               = out_ctrl_r[fdc_regs_pkg::OC_SEL_LSB +: 2];
	assign motor_a_on         = out_ctrl_r[fdc_regs_pkg::OC_MOTOR_A];
	assign motor_b_on         = out_ctrl_r[fdc_regs_pkg::OC_MOTOR_B];
	assign motor_a_out_n      = ~motor_a_on;
	assign motor_b_out_n      = ~motor_b_on;
	assign select_a_out_n     = ~(dsel == 2'h0);
	assign select_b_out_n     = ~(dsel == 2'h1);
	assign drive_c_selected_n = ~(dsel == 2'h2);
	assign drive_d_selected_n = ~(dsel == 2'h3);
	assign ctrl_reset_n       = out_ctrl_r[fdc_regs_pkg::OC_RESET_N];
	assign dma_irq_enable     = out_ctrl_r[fdc_regs_pkg::OC_DMA_EN];
	assign soft_reset_pulse   = sreset_r;
	assign power_down         = pdown_r;
	assign tape_select        = tape_sel_r;
	assign no_precomp         = noprec_r;
	assign fifo_enabled       = fifo_en_r;
	assign fifo_wr_pulse      = fwr_r;
	assign fifo_wdata         = fwdata_r;

	// ****************************************************************
	// Rate and precompensation
	// ****************************************************************
	logic        tape_2m;
	logic        lwc_r;
	logic        lwc_nxt;
	logic        t2m_r;
	logic        t2m_nxt;
	logic [15:0] delay_r;
	logic [15:0] delay_nxt;
	logic [15:0] default_delay;

	// [RQ20] tape rate needs both codes
	assign tape_2m = (rate_r == fdc_regs_pkg::RATE_300K) &&
		(tape_rate_code == fdc_regs_pkg::TAPE_RATE_2M);

	always_comb begin
		// [RQ19] low write current per rate
		lwc_nxt = (rate_r == fdc_regs_pkg::RATE_500K) || (rate_r == fdc_regs_pkg::RATE_1M);
		t2m_nxt = tape_2m;
		// [RQ18] default delay by rate
		if (tape_2m) begin
			default_delay = fdc_regs_pkg::DEFAULT_2M;
		end else if (rate_r == fdc_regs_pkg::RATE_1M) begin
			default_delay = fdc_regs_pkg::DEFAULT_1M;
		end else begin
			default_delay = fdc_regs_pkg::DEFAULT_LOW_RATE;
		end
		// [RQ17] step table, halved for tape
		if (shift_r == fdc_regs_pkg::SHIFT_DEFAULT) begin
			delay_nxt = default_delay;
		end else if (tape_2m) begin
			delay_nxt = fdc_regs_pkg::DELAY_TAPE[shift_r];
		end else begin
			delay_nxt = fdc_regs_pkg::DELAY_NORMAL[shift_r];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lwc_r   <= 1'b1;
			t2m_r   <= 1'b0;
			delay_r <= fdc_regs_pkg::DEFAULT_LOW_RATE;
		end else begin
			lwc_r   <= lwc_nxt;
			t2m_r   <= t2m_nxt;
			delay_r <= delay_nxt;
		end
	end

	assign rate_code         = rate_r;
	assign low_write_current = lwc_r;
	assign tape_2m_rate      = t2m_r;
	assign precomp_delay     = delay_r;

	// ****************************************************************
	// Edge trackers
	// ****************************************************************
	// Latches are emptied while the controller reset bit holds it in reset, except in a cycle where a rising edge sets them
	edge_track_if wd_if ();
	edge_track_if rd_if ();
	edge_track_if we_if ();
	edge_track_if st_if ();

	assign wd_if.level = write_serial_out;
	assign rd_if.level = rdata_s;
	assign we_if.level = ~write_gate_n;
	assign st_if.level = ~step_out_n;
	assign wd_if.clr   = ~ctrl_reset_n;
	assign rd_if.clr   = ~ctrl_reset_n;
	assign we_if.clr   = ~ctrl_reset_n;
	assign st_if.clr   = ~ctrl_reset_n;

	edge_track u_wd (.clk_sys(clk_sys), .rst_n(rst_n), .trk(wd_if));
	edge_track u_rd (.clk_sys(clk_sys), .rst_n(rst_n), .trk(rd_if));
	edge_track u_we (.clk_sys(clk_sys), .rst_n(rst_n), .trk(we_if));
	edge_track u_st (.clk_sys(clk_sys), .rst_n(rst_n), .trk(st_if));

	// ****************************************************************
	// Status bytes
	// ****************************************************************
	logic [7:0] stat_a;
	logic [7:0] stat_b;
	logic [7:0] tape_rd;
	logic [7:0] check_rd;

	always_comb begin
		// [RQ2] interrupt level
		stat_a[7] = irq_level;
		if (is_secondary) begin
			// [RQ5] DMA request and step latch
			stat_a[6] = dma_request_out;
			stat_a[5] = ~st_if.flag;
			// [RQ6] inverted polarities
			stat_a[4] = ~trk0_s;
			stat_a[3] = head_out_n;
			stat_a[2] = ~index_s;
			stat_a[1] = ~wp_n_s;
			stat_a[0] = ~dir_out;
			stat_b[7] = second_drive_flag;
			// [RQ9] select pins
			stat_b[6] = select_b_out_n;
			stat_b[5] = select_a_out_n;
			// [RQ10] inverted latches
			stat_b[4] = ~wd_if.flag;
			stat_b[3] = ~rd_if.flag;
			stat_b[2] = ~we_if.flag;
			// [RQ9] drive D and C
			stat_b[1] = drive_d_selected_n;
			stat_b[0] = drive_c_selected_n;
		end else begin
			stat_a[6] = second_drive_flag;
			// [RQ3] step, track, side, index
			stat_a[5] = ~step_out_n;
			stat_a[4] = trk0_s;
			stat_a[3] = ~head_out_n;
			stat_a[2] = index_s;
			// [RQ4] protect and direction
			stat_a[1] = wp_n_s;
			stat_a[0] = dir_out;
			stat_b[7] = 1'b1;
			stat_b[6] = 1'b1;
			// [RQ7] select bit and outputs
			stat_b[5] = dsel[0];
			// [RQ8] data edge toggles
			stat_b[4] = wd_if.toggle;
			stat_b[3] = rd_if.toggle;
			// [RQ7] gate and motors
			stat_b[2] = ~write_gate_n;
			stat_b[1] = motor_b_on;
			stat_b[0] = motor_a_on;
		end
		tape_rd = {6'h00, tape_sel_r};
		if (three_rate_enable) begin
			// [RQ13] media ID and boot drive
			tape_rd[7:6] = config_reg_eight[3:2];
			tape_rd[3:2] = config_reg_eight[1:0];
			// [RQ14] pair of last selected drive
			tape_rd[5:4] = drive_type_config[{dsel, 1'b0} +: 2];
		end
		if (is_secondary) begin
			check_rd = {media_changed_in_s, 3'h7, dma_irq_enable, noprec_r, rate_r};
		end else begin
			// [RQ24] ones and rate code
			check_rd = {~media_changed_in_s, 4'hF, rate_r,
				~((rate_r == fdc_regs_pkg::RATE_500K) || (rate_r == fdc_regs_pkg::RATE_1M))};
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [7:0] oe_n_r;
	logic [7:0] oe_n_nxt;
	logic       frd_r;
	logic       frd_nxt;
	logic [1:0] st0_r;
	logic [1:0] st0_nxt;

	always_comb begin
		rdata_nxt = fdc_regs_pkg::BYTE_ZERO;
		oe_n_nxt  = fdc_regs_pkg::BYTE_ONES;
		frd_nxt   = 1'b0;
		// [RQ22] interrupt code priority
		if (cmd_invalid) begin
			st0_nxt = fdc_regs_pkg::INT_CODE_INVALID;
		end else if (ready_changed) begin
			st0_nxt = fdc_regs_pkg::INT_CODE_READY_CH;
		end else begin
			st0_nxt = normal_int_code;
		end
		if (bus_cs && bus_rd) begin
			oe_n_nxt = fdc_regs_pkg::BYTE_ZERO;
			unique case (bus_addr)
				// [RQ1] status A and B offsets
				fdc_regs_pkg::OFF_PIN_STATUS_A:  rdata_nxt = stat_a;
				fdc_regs_pkg::OFF_PIN_STATUS_B:  rdata_nxt = stat_b;
				fdc_regs_pkg::OFF_TAPE_ASSIGN:   rdata_nxt = tape_rd;
				fdc_regs_pkg::OFF_MAIN_RATE:     rdata_nxt = main_flow_status;
				fdc_regs_pkg::OFF_CMD_DATA_FIFO: begin
					rdata_nxt = fifo_rdata;
					frd_nxt   = 1'b1;
				end
				fdc_regs_pkg::OFF_INPUT_CHECK: begin
					rdata_nxt = check_rd;
					// [RQ23] AT mode drives bit 7 only
					if (is_at) begin
						rdata_nxt = {~media_changed_in_s, 7'h00};
						oe_n_nxt  = 8'h7F;
					end
				end
				// Write-only and unmapped offsets leave the bus floating
				default: oe_n_nxt = fdc_regs_pkg::BYTE_ONES;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= fdc_regs_pkg::BYTE_ZERO;
			oe_n_r  <= fdc_regs_pkg::BYTE_ONES;
			frd_r   <= 1'b0;
			st0_r   <= 2'h0;
		end else begin
			rdata_r <= rdata_nxt;
			oe_n_r  <= oe_n_nxt;
			frd_r   <= frd_nxt;
			st0_r   <= st0_nxt;
		end
	end

	assign bus_rdata      = rdata_r;
	assign bus_rdata_oe_n = oe_n_r;
	assign fifo_rd_pulse  = frd_r;
	assign st0_int_code   = st0_r;
endmodule

// File: tb/fdc_host_asserts.sv
// Port checks for the floppy host register bank
`timescale 1ns/10ps
module fdc_host_asserts (
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic       bus_cs,
	input wire logic       bus_rd,
	input wire logic       bus_wr,
	input wire logic [2:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata,
	input wire logic [7:0] bus_rdata_oe_n,
	input wire logic [1:0] compat_mode,
	input wire logic       irq_level,
	input wire logic       cmd_invalid,
	input wire logic       ctrl_reset_n,
	input wire logic       soft_reset_pulse,
	input wire logic       power_down,
	input wire logic [1:0] rate_code,
	input wire logic       low_write_current,
	input wire logic [1:0] st0_int_code
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence s_rd(a);
		bus_cs && bus_rd && bus_addr == a;
	endsequence
	sequence s_wr4;
		bus_cs && bus_wr && bus_addr == 3'h4;
	endsequence
	sequence s_one_pulse;
		soft_reset_pulse ##1 !soft_reset_pulse;
	endsequence
	a_oc_cleared: assert property ($rose(rst_n) |-> !ctrl_reset_n)
		else $error("controller reset not held after master reset");
	a_irq_bit: assert property (s_rd(3'h0) |=> bus_rdata[7] == $past(irq_level))
		else $error("status bit 7 differs from interrupt level");
	a_read_release: assert property (s_rd(3'h1) ##1 !bus_rd |=> bus_rdata_oe_n == 8'hFF)
		else $error("read data still driven");
	a_soft_reset: assert property (s_wr4 ##0 bus_wdata[7] |=> s_one_pulse)
		else $error("soft reset not a single pulse");
	a_power_down: assert property (s_wr4 |=> power_down == $past(bus_wdata[6]))
		else $error("power down bit not taken");
	a_lwc_rate: assert property (low_write_current == $past(rate_code inside {2'h0, 2'h3}))
		else $error("low write current wrong for rate");
	a_at_check: assert property (compat_mode == 2'h0 ##0 s_rd(3'h7)
		|=> bus_rdata_oe_n == 8'h7F)
		else $error("input check enables wrong");
	a_st0_code: assert property (cmd_invalid |=> st0_int_code == 2'h2)
		else $error("invalid command code wrong");
endmodule

// File: tb/drive_pins_model.sv
// Drive-side model: read pulses from a spinning disk
`timescale 1ns/10ps
module drive_pins_model (
	input  wire logic clk_sys,
	input  wire logic spin,
	output logic      read_data_in
);
	logic [3:0] phase_r;
	// Idle disk keeps the pin low, so no stray edges reach the toggles
	always_ff @(posedge clk_sys) begin
		phase_r <= spin ? phase_r + 4'h1 : 4'h0;
	end
	assign read_data_in = phase_r[1];
endmodule

// File: tb/floppy_host_status_regs_test.sv
// Self-checking bench for the floppy host register bank
`timescale 1ns/10ps
module floppy_host_status_regs_test;
	logic clk_sys, rst_n, bus_cs, bus_rd, bus_wr, three_rate_enable, second_drive_flag, spin;
	logic irq_level, dma_request_out, step_out_n, head_out_n, dir_out, write_gate_n;
	logic write_serial_out, cfg_strobe, cfg_fifo_enable, cmd_invalid, ready_changed;
	logic track_zero_in, index_in, write_protect_n, read_data_in, media_changed_in;
	logic motor_a_out_n, motor_b_out_n, select_a_out_n, select_b_out_n, drive_c_selected_n;
	logic drive_d_selected_n, ctrl_reset_n, dma_irq_enable, soft_reset_pulse, power_down;
	logic low_write_current, tape_2m_rate, no_precomp, fifo_enabled, fifo_wr_pulse;
	logic fifo_rd_pulse;
	logic [1:0] compat_mode, tape_rate_code, normal_int_code, rate_code, tape_select;
	logic [1:0] st0_int_code;
	logic [2:0] bus_addr;
	logic [3:0] config_reg_eight;
	logic [7:0] bus_wdata, bus_rdata, bus_rdata_oe_n, drive_type_config, main_flow_status;
	logic [7:0] fifo_rdata, fifo_wdata, rd_v, rd_oe, r0;
	logic [15:0] precomp_delay;
	int fails, n_compared;

	floppy_host_status_regs i_dut (.*);
	drive_pins_model i_drive (.clk_sys(clk_sys), .spin(spin), .read_data_in(read_data_in));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// ****************************************
	// Bus and check helpers
	// ****************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		{bus_cs, bus_wr, bus_addr, bus_wdata} = {2'b11, a, d};
		idle(1);
		{bus_cs, bus_wr} = 2'b00;
		idle(1);
	endtask
	task automatic rd(input logic [2:0] a);
		{bus_cs, bus_rd, bus_addr} = {2'b11, a};
		idle(1);
		{bus_cs, bus_rd, rd_v, rd_oe} = {2'b00, bus_rdata, bus_rdata_oe_n};
		idle(1);
	endtask
	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_pins();
		chk("reset pins", 6'b000110, {ctrl_reset_n, dma_irq_enable, select_a_out_n,
			motor_a_out_n, motor_b_out_n, fifo_enabled});
		{irq_level, second_drive_flag, step_out_n, track_zero_in, head_out_n} = 5'b10111;
		{index_in, write_protect_n, dir_out, compat_mode} = 5'b10101;
		idle(4);
		rd(3'h0);
		chk("status_a primary", 8'h95, rd_v);
		compat_mode = 2'h2;
		rd(3'h0);
		chk("status_a secondary", 8'hAA, rd_v);
		wr(3'h2, 8'h35);
		compat_mode = 2'h1;
		rd(3'h1);
		chk("status_b primary", 8'hE7, rd_v & 8'hE7);
		r0 = rd_v;
		{write_serial_out, spin, step_out_n} = 3'b110;
		idle(12);
		{write_serial_out, spin, step_out_n} = 3'b001;
		idle(6);
		rd(3'h1);
		chk("status_b toggles", {~r0[4:3]}, rd_v[4:3]);
		compat_mode = 2'h2;
		rd(3'h1);
		chk("status_b secondary", 8'h23, rd_v & 8'h7B);
		rd(3'h0);
		chk("step latch", 1'b0, rd_v[5]);
		$display("pin status test done");
	endtask
	task automatic t_tape();
		for (int v = 0; v < 4; v++) begin
			wr(3'h3, 8'(v));
			rd(3'h3);
			chk("tape plain", 16'(v), rd_v);
		end
		{three_rate_enable, config_reg_eight, drive_type_config} = {1'b1, 4'hB, 8'hE4};
		rd(3'h3);
		chk("tape three mode", 8'h9F, rd_v);
		$display("tape test done");
	endtask
	task automatic t_rate();
		for (int c = 0; c < 4; c++) begin
			wr(3'h4, 8'(c));
			chk("rate and current", {c[1:0], c == 0 || c == 3}, {rate_code, low_write_current});
			chk("default delay", c == 3 ? 16'd4167 : 16'd12500, precomp_delay);
		end
		for (int s = 1; s < 8; s++) begin
			wr(3'h4, {3'h0, 3'(s), 2'h2});
			chk("shift delay", fdc_regs_pkg::DELAY_NORMAL[s], precomp_delay);
		end
		tape_rate_code = 2'h2;
		wr(3'h4, 8'h05);
		chk("tape delay", 16'd2080, precomp_delay);
		wr(3'h4, 8'h41);
		chk("tape default", {16'd2080}, precomp_delay);
		chk("tape rate power", 2'b11, {tape_2m_rate, power_down});
		wr(3'h7, 8'h07);
		chk("config rate", 4'hD, {rate_code, tape_2m_rate, no_precomp});
		wr(3'h4, 8'h02);
		chk("latest rate", 2'h2, rate_code);
		$display("rate test done");
	endtask
	task automatic t_misc();
		{media_changed_in, compat_mode} = 3'b100;
		idle(4);
		rd(3'h7);
		chk("check AT", 9'h07F, {rd_v[7], rd_oe});
		compat_mode = 2'h1;
		rd(3'h7);
		chk("check primary", 8'h7D, rd_v);
		{cfg_strobe, cfg_fifo_enable} = 2'b11;
		idle(1);
		cfg_strobe = 1'b0;
		idle(1);
		chk("fifo enabled", 1'b1, fifo_enabled);
		{cmd_invalid, ready_changed} = 2'b11;
		idle(2);
		chk("st0 invalid", 2'h2, st0_int_code);
		cmd_invalid = 1'b0;
		idle(2);
		chk("st0 ready", 2'h3, st0_int_code);
		wr(3'h4, 8'h80);
		$display("misc test done");
	endtask

	initial begin
		{bus_cs, bus_rd, bus_wr, bus_addr, bus_wdata, cfg_strobe, cfg_fifo_enable} = '0;
		{cmd_invalid, ready_changed, compat_mode, three_rate_enable, config_reg_eight} = '0;
		{drive_type_config, tape_rate_code, fails, n_compared} = '0;
		{irq_level, second_drive_flag, dma_request_out, step_out_n, head_out_n} = 5'b00011;
		{dir_out, write_gate_n, write_serial_out, track_zero_in, index_in} = 5'b10000;
		{write_protect_n, media_changed_in, spin, rst_n} = 4'b1000;
		{main_flow_status, fifo_rdata, normal_int_code} = {8'h5A, 8'hC3, 2'h1};
		idle(2);
		rst_n = 1'b1;
		idle(1);
		t_pins();
		t_tape();
		t_rate();
		t_misc();
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		summarize();
	end
endmodule

bind floppy_host_status_regs fdc_host_asserts i_chk (.*);
